// ===== verilog/aneg_regs_consts.svh
`ifndef ANEG_REGS_CONSTS_SVH
`define ANEG_REGS_CONSTS_SVH
// Register offsets on the management port (word index).
`define ADDR_ADVERT 4'h4
`define ADDR_PARTNER 4'h5
`define ADDR_EXPANSION 4'h6
`define ADDR_IRQ_STATUS 4'h8
`define ADDR_IRQ_MASK 4'h9
// Field positions.
`define ADV_10FD_BIT 6
`define ADV_10HD_BIT 5
`define EXP_PD_FAULT_BIT 4
`define EXP_LP_NP_BIT 3
`define EXP_LOC_NP_BIT 2
`define EXP_PAGE_RX_BIT 1
`define EXP_LP_AN_BIT 0
`define LP_NP_BIT 15
`define SEL_HI 4
`define SEL_LO 0
`define IRQ_PAGE_BIT 0
`define IRQ_FAULT_BIT 1
// Last count of the strap wait: the synchroniser is full after this many enabled cycles.
`define STRAP_LAST 2'h2
`define LOC_NP_ABLE 1'b1
// Reset values.
`define SELECTOR_RESET 5'h01
`define ZERO16 16'h0000
`define IRQ_WIDTH 2
`define IRQ_ZERO 2'h0
`endif

// ===== verilog/aneg_regs_pkg.sv
`default_nettype none
package aneg_regs_pkg;
   typedef struct packed {
      logic [15:0] addr_data;
   } word_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } mgmt_req_t;
   // Advertised ability set handed to the negotiation engine.
   typedef struct packed {
      logic force_1000;
      logic force_full;
      logic [15:0] base_page;
   } advert_out_t;
endpackage
`default_nettype wire

// ===== verilog/copper_autoneg_ability_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "aneg_regs_consts.svh"
module copper_autoneg_ability_regs
   import aneg_regs_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Management port
   input wire mgmt_req_t mgmt,
   output logic [15:0] rdata,
   // Straps and control inputs from the device
   input wire logic advertise_strap_input,
   input wire logic soft_reset,
   input wire logic restart_aneg,
   input wire logic power_up_event,
   input wire logic link_down_event,
   input wire logic aneg_enable,
   input wire logic forced_1000,
   input wire logic duplex_full,
   // Negotiation engine side
   input wire logic [15:0] rx_base_page,
   input wire logic rx_page_valid,
   input wire logic partner_aneg_able,
   input wire logic pd_fault,
   output advert_out_t advert,
   // Interrupt
   output logic irq
);
   logic strap_meta_r;
   logic strap_sync_r;
   logic strap_loaded_r;
   logic [1:0] adv10_pend_r;
   logic [1:0] adv10_r;
   logic [4:0] selector_r;
   logic [15:0] partner_r;
   logic lp_an_r;
   logic pd_fault_r;
   logic page_rx_r;
   logic [15:0] exp_w;
   logic [15:0] rdata_nxt;
   logic [`IRQ_WIDTH-1:0] irq_status_r;
   logic [`IRQ_WIDTH-1:0] irq_mask_r;
   logic apply_w;
   logic wr_adv;
   logic rd_exp;

   assign wr_adv = mgmt.wr && mgmt.addr == `ADDR_ADVERT;
   assign rd_exp = mgmt.rd && mgmt.addr == `ADDR_EXPANSION;
   assign apply_w = soft_reset || restart_aneg || power_up_event || link_down_event;

   // The strap is a pin, so it is synchronised before use.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_meta_r <= 1'b0;
         strap_sync_r <= 1'b0;
      end else if (clk_en) begin
         strap_meta_r <= advertise_strap_input;
         strap_sync_r <= strap_meta_r;
      end
   end

   // Strap is caught after release, once the synchroniser has filled.
   logic [1:0] strap_wait_r;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_wait_r <= 2'h0;
         strap_loaded_r <= 1'b0;
      end else if (clk_en) begin
         if (strap_wait_r != `STRAP_LAST) begin
            strap_wait_r <= strap_wait_r + 2'h1;
         end else begin
            strap_loaded_r <= 1'b1;
         end
      end
   end

   // Pending value is what software sees; active value goes to the engine.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         adv10_pend_r <= 2'h0;
         adv10_r <= 2'h0;
         selector_r <= `SELECTOR_RESET;
      end else if (clk_en) begin
         if (!strap_loaded_r) begin
            adv10_pend_r <= {2{strap_sync_r}};
            adv10_r <= {2{strap_sync_r}};
         end else begin
            if (wr_adv) begin
               adv10_pend_r <= {mgmt.wdata[`ADV_10FD_BIT], mgmt.wdata[`ADV_10HD_BIT]};
               selector_r <= mgmt.wdata[`SEL_HI:`SEL_LO];
            end
            if (apply_w) begin
               adv10_r <= wr_adv ? {mgmt.wdata[`ADV_10FD_BIT], mgmt.wdata[`ADV_10HD_BIT]}
                                 : adv10_pend_r;
            end
         end
      end
   end

   property p_apply_only;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && strap_loaded_r && $past(strap_loaded_r) && !apply_w) |=> $stable(adv10_r);
   endproperty
   a_apply_only: assert property (p_apply_only) else $error("advert changed without trigger");

   property p_strap_load;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && !strap_loaded_r) |=>
            adv10_r[1] == $past(strap_sync_r) && adv10_r[0] == $past(strap_sync_r);
   endproperty
   a_strap_load: assert property (p_strap_load) else $error("strap not loaded");

   property p_pend_write;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && strap_loaded_r && wr_adv) |=>
            adv10_pend_r[1] == $past(mgmt.wdata[`ADV_10FD_BIT]) &&
            adv10_pend_r[0] == $past(mgmt.wdata[`ADV_10HD_BIT]);
   endproperty
   a_pend_write: assert property (p_pend_write) else $error("pending advert not written");

   property p_apply;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && strap_loaded_r && apply_w && !wr_adv) |=> adv10_r == $past(adv10_pend_r);
   endproperty
   a_apply: assert property (p_apply) else $error("pending advert not applied");

   // Forced gigabit replaces the low abilities; upper bits belong to other blocks.
   always_comb begin
      advert.force_1000 = !aneg_enable && forced_1000;
      advert.force_full = duplex_full;
      advert.base_page = `ZERO16;
      advert.base_page[`SEL_HI:`SEL_LO] = selector_r;
      if (!(!aneg_enable && forced_1000)) begin
         advert.base_page[`ADV_10FD_BIT] = adv10_r[1];
         advert.base_page[`ADV_10HD_BIT] = adv10_r[0];
      end
   end

   property p_forced;
      @(posedge ref_clk) disable iff (!reset_n)
         (!aneg_enable && forced_1000) |->
            !advert.base_page[`ADV_10FD_BIT] && !advert.base_page[`ADV_10HD_BIT];
   endproperty
   a_forced: assert property (p_forced) else $error("low abilities leaked in forced mode");

   property p_force_flag;
      @(posedge ref_clk) disable iff (!reset_n)
         aneg_enable |-> !advert.force_1000;
   endproperty
   a_force_flag: assert property (p_force_flag) else $error("forced flag while negotiating");

   property p_adv_sel;
      @(posedge ref_clk) disable iff (!reset_n)
         advert.base_page[`SEL_HI:`SEL_LO] == selector_r;
   endproperty
   a_adv_sel: assert property (p_adv_sel) else $error("selector not advertised");

   // Partner image: a straight copy of each base page received while soft_reset is low.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         partner_r <= `ZERO16;
         lp_an_r <= 1'b0;
      end else if (clk_en) begin
         if (soft_reset) begin
            partner_r <= `ZERO16;
            lp_an_r <= 1'b0;
         end else begin
            if (rx_page_valid) begin
               partner_r <= rx_base_page;
            end
            lp_an_r <= partner_aneg_able;
         end
      end
   end

   property p_copy;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && rx_page_valid && !soft_reset) |=> partner_r == $past(rx_base_page);
   endproperty
   a_copy: assert property (p_copy) else $error("partner image mismatch");

   property p_partner_hold;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && !rx_page_valid && !soft_reset) |=> $stable(partner_r);
   endproperty
   a_partner_hold: assert property (p_partner_hold) else $error("partner image moved");

   property p_soft;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && soft_reset && !wr_adv) |=> partner_r == `ZERO16 && $stable(selector_r);
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset effect wrong");

   property p_lp_an;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && !soft_reset) |=> lp_an_r == $past(partner_aneg_able);
   endproperty
   a_lp_an: assert property (p_lp_an) else $error("partner ability not shown");

   // Latched flags: set beats the read that would clear them.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pd_fault_r <= 1'b0;
         page_rx_r <= 1'b0;
      end else if (clk_en) begin
         if (soft_reset) begin
            pd_fault_r <= pd_fault;
            page_rx_r <= rx_page_valid;
         end else begin
            pd_fault_r <= pd_fault || (pd_fault_r && !rd_exp);
            page_rx_r <= rx_page_valid || (page_rx_r && !rd_exp);
         end
      end
   end

   property p_pd_latch;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && pd_fault && !soft_reset) |=> pd_fault_r;
   endproperty
   a_pd_latch: assert property (p_pd_latch) else $error("fault not latched");

   property p_pd_hold;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && pd_fault_r && !rd_exp && !soft_reset) |=> pd_fault_r;
   endproperty
   a_pd_hold: assert property (p_pd_hold) else $error("fault flag dropped");

   property p_page_set;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && rx_page_valid) |=> page_rx_r;
   endproperty
   a_page_set: assert property (p_page_set) else $error("page flag not set");

   property p_page_hold;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && page_rx_r && !rd_exp && !soft_reset) |=> page_rx_r;
   endproperty
   a_page_hold: assert property (p_page_hold) else $error("page flag dropped");

   property p_read_clear;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && rd_exp && !rx_page_valid) |=> !page_rx_r;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("page flag not cleared");

   always_comb begin
      exp_w = `ZERO16;
      exp_w[`EXP_PD_FAULT_BIT] = pd_fault_r;
      exp_w[`EXP_LP_NP_BIT] = partner_r[`LP_NP_BIT];
      exp_w[`EXP_LOC_NP_BIT] = `LOC_NP_ABLE;
      exp_w[`EXP_PAGE_RX_BIT] = page_rx_r;
      exp_w[`EXP_LP_AN_BIT] = lp_an_r;
   end

   property p_np;
      @(posedge ref_clk) disable iff (!reset_n)
         exp_w[`EXP_LP_NP_BIT] == partner_r[`LP_NP_BIT] && exp_w[`EXP_LOC_NP_BIT];
   endproperty
   a_np: assert property (p_np) else $error("next page bits wrong");

   // Interrupt status: bit 0 page received, bit 1 parallel fault; write one clears.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status_r <= `IRQ_ZERO;
         irq_mask_r <= `IRQ_ZERO;
      end else if (clk_en) begin
         if (mgmt.wr && mgmt.addr == `ADDR_IRQ_MASK) begin
            irq_mask_r <= mgmt.wdata[`IRQ_WIDTH-1:0];
         end
         irq_status_r <= {pd_fault, rx_page_valid} |
                         (irq_status_r & ~((mgmt.wr && mgmt.addr == `ADDR_IRQ_STATUS)
                                           ? mgmt.wdata[`IRQ_WIDTH-1:0] : `IRQ_ZERO));
      end
   end

   // A set mask bit keeps its status bit off the interrupt line.
   assign irq = |(irq_status_r & ~irq_mask_r);

   property p_irq_page;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && rx_page_valid) |=> irq_status_r[`IRQ_PAGE_BIT];
   endproperty
   a_irq_page: assert property (p_irq_page) else $error("page event not recorded");

   property p_irq_fault;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && pd_fault) |=> irq_status_r[`IRQ_FAULT_BIT];
   endproperty
   a_irq_fault: assert property (p_irq_fault) else $error("fault event not recorded");

   always_comb begin
      rdata_nxt = `ZERO16;
      unique case (mgmt.addr)
         `ADDR_ADVERT: begin
            rdata_nxt[`ADV_10FD_BIT] = adv10_pend_r[1];
            rdata_nxt[`ADV_10HD_BIT] = adv10_pend_r[0];
            rdata_nxt[`SEL_HI:`SEL_LO] = selector_r;
         end
         `ADDR_PARTNER: rdata_nxt = partner_r;
         `ADDR_EXPANSION: rdata_nxt = exp_w;
         `ADDR_IRQ_STATUS: rdata_nxt[`IRQ_WIDTH-1:0] = irq_status_r;
         `ADDR_IRQ_MASK: rdata_nxt[`IRQ_WIDTH-1:0] = irq_mask_r;
         default: rdata_nxt = `ZERO16;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= `ZERO16;
      end else if (clk_en) begin
         rdata <= mgmt.rd ? rdata_nxt : `ZERO16;
      end
   end

   property p_read;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && mgmt.rd && mgmt.addr == `ADDR_EXPANSION) |=> rdata[`EXP_LOC_NP_BIT];
   endproperty
   a_read: assert property (p_read) else $error("expansion read wrong");

   property p_rdata_idle;
      @(posedge ref_clk) disable iff (!reset_n)
         (clk_en && !mgmt.rd) |=> rdata == `ZERO16;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");

   property p_freeze;
      @(posedge ref_clk) disable iff (!reset_n)
         !clk_en |=> $stable(adv10_r) && $stable(partner_r) && $stable(irq_status_r);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule
`default_nettype wire

// ===== tb/link_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
   // Clock
   input wire logic ref_clk,
   // Received page toward the device
   output logic [15:0] rx_base_page,
   output logic rx_page_valid,
   output logic partner_aneg_able
);
   initial begin
      rx_base_page = 16'h0000;
      rx_page_valid = 1'b0;
      partner_aneg_able = 1'b0;
   end
   task automatic send(input logic [15:0] p);
      @(posedge ref_clk);
      partner_aneg_able <= 1'b1;
      rx_base_page <= p;
      rx_page_valid <= 1'b1;
      @(posedge ref_clk);
      rx_page_valid <= 1'b0;
      // The word is meaningless without the strobe, so show its inverse to catch a late capture.
      rx_base_page <= ~p;
   endtask
endmodule
`default_nettype wire

// ===== tb/test_copper_autoneg_ability_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "aneg_regs_consts.svh"
module test_copper_autoneg_ability_regs;
   import aneg_regs_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   mgmt_req_t mgmt = '0;
   logic [15:0] rdata;
   logic [3:0] trig = 4'h0;
   logic f1000 = 1'b0;
   logic dfull = 1'b0;
   logic pd = 1'b0;
   logic an_en = 1'b1;
   logic ce = 1'b1;
   logic strap = 1'b1;
   logic [15:0] rxp;
   logic rxv;
   logic lp_able;
   advert_out_t advert;
   logic irq;
   logic [15:0] v;
   logic [15:0] pg;
   logic [1:0] nv;
   int miscompares = 0;
   int n_compared = 0;
   always #5 ref_clk = ~ref_clk;
   copper_autoneg_ability_regs copper_autoneg_ability_regs_i (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(ce), .mgmt(mgmt), .rdata(rdata),
      .advertise_strap_input(strap), .soft_reset(trig[0]), .restart_aneg(trig[1]),
      .power_up_event(trig[2]), .link_down_event(trig[3]), .aneg_enable(an_en),
      .forced_1000(f1000), .duplex_full(dfull), .rx_base_page(rxp), .rx_page_valid(rxv),
      .partner_aneg_able(lp_able), .pd_fault(pd), .advert(advert), .irq(irq));
   link_partner_model link_partner_model_i (.ref_clk(ref_clk), .rx_base_page(rxp),
      .rx_page_valid(rxv), .partner_aneg_able(lp_able));
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      mgmt <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      mgmt.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      mgmt <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      mgmt.rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic chk_force(input string n, input logic [3:0] e);
      @(posedge ref_clk);
      #1 chk(n, {12'h000, advert.force_1000, advert.force_full, advert.base_page[6:5]},
             {12'h000, e});
   endtask
   task automatic pulse(input int i);
      @(posedge ref_clk);
      trig[i] <= 1'b1;
      @(posedge ref_clk);
      trig[i] <= 1'b0;
      #1;
   endtask
   task automatic close_out();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge ref_clk);
      miscompares++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      // The strap passes a two-flop synchroniser before it lands in the advert bits.
      repeat (6) @(posedge ref_clk);
      rd(`ADDR_ADVERT);
      chk("adv", v & 16'h007F, 16'h0061);
      rd(`ADDR_PARTNER);
      chk("lp", v, 16'h0000);
      rd(`ADDR_EXPANSION);
      chk("exp", v, 16'h0004);
      for (int i = 0; i < 4; i++) begin
         nv = i[0] ? 2'b11 : 2'b00;
         wr(`ADDR_ADVERT, {9'h000, nv, 5'h01});
         rd(`ADDR_ADVERT);
         chk("adv_rb", {14'h0000, v[6:5]}, {14'h0000, nv});
         chk("adv_held", {14'h0000, advert.base_page[6:5]}, {14'h0000, ~nv});
         pulse(i);
         chk("adv_new", {14'h0000, advert.base_page[6:5]}, {14'h0000, nv});
      end
      wr(`ADDR_ADVERT, 16'h0062);
      pulse(0);
      rd(`ADDR_ADVERT);
      chk("sel", v & 16'h007F, 16'h0062);
      chk("adv_page", advert.base_page, 16'h0062);
      @(posedge ref_clk);
      f1000 <= 1'b1;
      dfull <= 1'b1;
      chk_force("frc_an", 4'b0111);
      @(posedge ref_clk);
      an_en <= 1'b0;
      chk_force("frc_fd", 4'b1100);
      @(posedge ref_clk);
      dfull <= 1'b0;
      chk_force("frc_hd", 4'b1000);
      @(posedge ref_clk);
      f1000 <= 1'b0;
      an_en <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         pg = k ? 16'h565E : 16'hA9A1;
         link_partner_model_i.send(pg);
         rd(`ADDR_PARTNER);
         chk("lp", v, pg);
         rd(`ADDR_EXPANSION);
         chk("exp", v, {12'h000, pg[15], 3'b111});
         rd(`ADDR_EXPANSION);
         chk("exp_clr", v, {12'h000, pg[15], 3'b101});
      end
      @(posedge ref_clk);
      ce <= 1'b0;
      pulse(0);
      @(posedge ref_clk);
      ce <= 1'b1;
      rd(`ADDR_PARTNER);
      chk("lp_frozen", v, pg);
      @(posedge ref_clk);
      pd <= 1'b1;
      @(posedge ref_clk);
      pd <= 1'b0;
      rd(`ADDR_EXPANSION);
      chk("pdf", {15'h0000, v[4]}, 16'h0001);
      rd(`ADDR_EXPANSION);
      chk("pdf_clr", {15'h0000, v[4]}, 16'h0000);
      rd(`ADDR_IRQ_STATUS);
      chk("irq_st", v, 16'h0003);
      chk("irq", {15'h0000, irq}, 16'h0001);
      wr(`ADDR_IRQ_MASK, 16'h0003);
      @(posedge ref_clk);
      #1 chk("irq_mask", {15'h0000, irq}, 16'h0000);
      wr(`ADDR_IRQ_MASK, 16'h0000);
      wr(`ADDR_IRQ_STATUS, 16'h0003);
      rd(`ADDR_IRQ_STATUS);
      chk("irq_st", v, 16'h0000);
      chk("irq", {15'h0000, irq}, 16'h0000);
      pulse(0);
      rd(`ADDR_PARTNER);
      chk("lp_sw", v, 16'h0000);
      rd(`ADDR_EXPANSION);
      chk("exp_sw", v, 16'h0005);
      rd(4'hF);
      chk("unmapped", v, 16'h0000);
      // A second hardware reset with the strap low must clear the 10 Mb/s bits and return the selector to its reset value 5'h01.
      @(posedge ref_clk);
      reset_n <= 1'b0;
      strap <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rd(`ADDR_ADVERT);
      chk("adv_hw", v & 16'h007F, 16'h0001);
      rd(`ADDR_PARTNER);
      chk("lp_hw", v, 16'h0000);
      close_out();
   end
endmodule
`default_nettype wire
